// [hdl/smsd_cfg.svh]
`ifndef SMSD_CFG_SVH
`define SMSD_CFG_SVH
// Register byte addresses
`define SMSD_CTRL_OFF 12'h000
`define SMSD_STAT_OFF 12'h004
`define SMSD_ISTAT_OFF 12'h008
`define SMSD_IMASK_OFF 12'h00c
// Control byte field positions
`define SMSD_CUR_HI_BIT 7
`define SMSD_CUR_LO_BIT 6
`define SMSD_OUT_EN_BIT 5
`define SMSD_SEL_BIT 4
`define SMSD_P3_BIT 3
`define SMSD_TSEL_HI_BIT 2
`define SMSD_TSEL_MID_BIT 1
`define SMSD_TSEL_LOW_BIT 0
// Reset values
`define SMSD_CTRL_RST 8'h30
// ADC thresholds at 0.15/0.3/0.45/0.6 of full scale, 10-bit sample scale
`define SMSD_ADC_FULL 10'h3ff
`define SMSD_ADC_T1 10'h099
`define SMSD_ADC_T2 10'h133
`define SMSD_ADC_T3 10'h1cc
`define SMSD_ADC_T4 10'h266
// Interrupt bits
`define SMSD_IRQ_LOCK 0
`define SMSD_IRQ_ADC 1
`endif

// [hdl/smsd_pkg.sv]
package smsd_pkg;
  typedef enum logic [5:0] {
    SMSD_NORMAL = 6'h01,
    SMSD_T_SINK = 6'h02,
    SMSD_T_SRC = 6'h04,
    SMSD_T_OFF = 6'h08,
    SMSD_T_PORT = 6'h10,
    SMSD_T_VAR = 6'h20
  } smsd_mode_t;
  typedef struct packed {
    logic pump_sink;
    logic pump_source;
    logic pump_off;
    logic port_div;
    logic varactor_off;
  } smsd_test_t;
  typedef struct packed {
    logic shared_out_en;
    logic shared_sel_comp;
    logic [1:0] pump_current;
  } smsd_out_t;
endpackage

// [hdl/smsd_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module smsd_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic s1_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_reg <= d;
      q <= s1_reg;
    end
  end
endmodule // smsd_sync
`default_nettype wire

// [hdl/smsd_adc.sv]
`timescale 1ns/100ps
`default_nettype none
`include "smsd_cfg.svh"
module smsd_adc (
  input wire logic [9:0] sample,
  output logic [2:0] code
);
  // Five ranges, ascending codes
  assign code = (sample >= `SMSD_ADC_T4) ? 3'h4 : // [R1]
                (sample >= `SMSD_ADC_T3) ? 3'h3 :
                (sample >= `SMSD_ADC_T2) ? 3'h2 :
                (sample >= `SMSD_ADC_T1) ? 3'h1 : 3'h0;
endmodule // smsd_adc
`default_nettype wire

// [hdl/smsd_top.sv]
// Overview of operation
// [R1] ADC sample quantised to five ranges at 0.15/0.3/0.45/0.6 supply, codes 0..4.
// [R2] Enable low forces shared output disabled and high, whatever select and test.
// [R3] Enable 0, select 1: test bits 00 sink, 01 source, 10 off, 11 port half-fpd.
// [R4] Pump test modes override lock: sink reports 1, source or off report 0.
// [R5] Pump disabled test code reports lock 0 regardless of real lock.
// [R6] In test mode high test bit disables varactor drive output.
// [R7] Two current bits select four pump currents, rising from 00 to 11.
// [R8] Host shares reference: master enable 1 select 0, slave enable 0 select 0.
// [R9] Enable 1 routes reference when select 0, comparison when select 1.
// [R10] Power up sets enable and select to 1, comparison on shared output.
// [R11] When test bits accepted, previous low three port values are kept.
// [R12] Status byte: power-loss, lock, three zeros, three ADC bits, MSB first.
// [R13] Mode, test and current are registered, changed only on accepted writes.
`timescale 1ns/100ps
`default_nettype none
`include "smsd_cfg.svh"
module smsd_top
  import smsd_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog side inputs
  input wire logic ref_osc_in,
  input wire logic comp_freq_in,
  input wire logic phase_detector_freq,
  input wire logic loop_locked,
  input wire logic [9:0] adc_sample,
  // Outputs
  output logic shared_out,
  output logic [3:0] port_out,
  output logic [1:0] pump_current,
  output logic pump_sink,
  output logic pump_source,
  output logic pump_off,
  output logic varactor_off,
  output logic irq
);
  import smsd_pkg::*;

  logic [7:0] ctrl_reg;
  logic [3:0] port_reg;
  logic por_reg;
  logic [1:0] istat_reg, imask_reg;
  logic ref_s, comp_s, fpd_s, lock_s;
  logic fpd_d_reg, half_reg;
  logic lock_rep_d_reg;
  logic [2:0] adc_d_reg;
  smsd_mode_t mode_reg;
  smsd_out_t out_reg;

  smsd_sync u_ref (.pclk(pclk), .presetn(presetn), .d(ref_osc_in), .q(ref_s));
  smsd_sync u_cmp (.pclk(pclk), .presetn(presetn), .d(comp_freq_in), .q(comp_s));
  smsd_sync u_fpd (.pclk(pclk), .presetn(presetn), .d(phase_detector_freq), .q(fpd_s));
  smsd_sync u_lck (.pclk(pclk), .presetn(presetn), .d(loop_locked), .q(lock_s));

  logic [2:0] adc_code;
  smsd_adc u_adc (.sample(adc_sample), .code(adc_code));

  // Bus decode
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire hit_ctrl = (paddr == `SMSD_CTRL_OFF);
  wire hit_stat = (paddr == `SMSD_STAT_OFF);
  wire hit_istat = (paddr == `SMSD_ISTAT_OFF);
  wire hit_imask = (paddr == `SMSD_IMASK_OFF);
  wire hit_any = hit_ctrl || hit_stat || hit_istat || hit_imask;
  wire ctrl_wr = wr_en && hit_ctrl;
  wire [7:0] wb = pwdata[7:0];
  wire w_out_en = wb[`SMSD_OUT_EN_BIT];
  wire w_sel = wb[`SMSD_SEL_BIT];
  wire w_test = !w_out_en && w_sel;

  // Mode decode from written byte
  wire [1:0] w_ts = {wb[`SMSD_TSEL_MID_BIT], wb[`SMSD_TSEL_LOW_BIT]};
  smsd_mode_t mode_next;
  assign mode_next = !w_test ? SMSD_NORMAL : // [R3]
                     (w_ts == 2'h0) ? SMSD_T_SINK :
                     (w_ts == 2'h1) ? SMSD_T_SRC :
                     (w_ts == 2'h2) ? SMSD_T_OFF : SMSD_T_PORT;
  // Ports keep old low bits while test bits are received
  wire [3:0] port_next = w_test ? {wb[`SMSD_P3_BIT], port_reg[2:0]} : wb[3:0]; // [R11]
  wire var_next = w_test && wb[`SMSD_TSEL_HI_BIT]; // [R6]
  logic var_reg;

  // Lock reporting
  wire lock_rep = (mode_reg == SMSD_T_SINK) ? 1'b1 : // [R4]
                  ((mode_reg == SMSD_T_SRC) || (mode_reg == SMSD_T_OFF)) ? 1'b0 : // [R5]
                  lock_s;
  wire [7:0] status = {por_reg, lock_rep, 3'h0, adc_code}; // [R12]

  // Shared output selection
  wire shared_next = !out_reg.shared_out_en ? 1'b1 : // [R2]
                     (out_reg.shared_sel_comp ? comp_s : ref_s); // [R9]
  wire half_next = (fpd_s && !fpd_d_reg) ? !half_reg : half_reg;
  wire [3:0] port_drive = (mode_reg == SMSD_T_PORT) ? {port_reg[3:1], half_reg} : port_reg; // [R3]

  // Events
  wire ev_lock = lock_rep != lock_rep_d_reg;
  wire ev_adc = adc_code != adc_d_reg;
  wire istat_wr = wr_en && hit_istat;
  wire [1:0] istat_next = ({ev_adc, ev_lock}) |
                          (istat_reg & ~(istat_wr ? pwdata[1:0] : 2'h0));

  wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_reg} :
                       hit_stat ? {24'h0, status} :
                       hit_istat ? {30'h0, istat_reg} :
                       hit_imask ? {30'h0, imask_reg} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SMSD_CTRL_RST; // [R10]
      out_reg <= '{1'b1, 1'b1, 2'h0}; // [R10]
      mode_reg <= SMSD_NORMAL;
      port_reg <= 4'h0;
      var_reg <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_reg <= wb; // [R13]
      out_reg <= '{w_out_en, w_sel, {wb[`SMSD_CUR_HI_BIT], wb[`SMSD_CUR_LO_BIT]}}; // [R7]
      mode_reg <= mode_next; // [R13]
      port_reg <= port_next;
      var_reg <= var_next;
    end
  end

  // Power-loss flag, cleared by a status read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_reg <= 1'b1;
    end else if (rd_en && hit_stat) begin
      por_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fpd_d_reg <= 1'b0;
      half_reg <= 1'b0;
      lock_rep_d_reg <= 1'b0;
      adc_d_reg <= 3'h0;
      istat_reg <= 2'h0;
      imask_reg <= 2'h0;
    end else begin
      fpd_d_reg <= fpd_s;
      half_reg <= half_next;
      lock_rep_d_reg <= lock_rep;
      adc_d_reg <= adc_code;
      istat_reg <= istat_next;
      if (wr_en && hit_imask) begin
        imask_reg <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      shared_out <= 1'b1;
      port_out <= 4'h0;
      pump_current <= 2'h0;
      pump_sink <= 1'b0;
      pump_source <= 1'b0;
      pump_off <= 1'b0;
      varactor_off <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : prdata;
      shared_out <= shared_next;
      port_out <= port_drive;
      pump_current <= out_reg.pump_current; // [R7]
      pump_sink <= mode_reg == SMSD_T_SINK; // [R3]
      pump_source <= mode_reg == SMSD_T_SRC;
      pump_off <= mode_reg == SMSD_T_OFF;
      varactor_off <= var_reg; // [R6]
      irq <= |(istat_next & imask_reg);
    end
  end

  // Checks
  shared_hi_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    !out_reg.shared_out_en |=> shared_out)
    else $error("shared output not high while disabled");
  sink_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    mode_reg == SMSD_T_SINK |-> status[6])
    else $error("lock not forced in sink test");
  off_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    (mode_reg == SMSD_T_OFF || mode_reg == SMSD_T_SRC) |-> !status[6])
    else $error("lock not cleared in pump test");
  test_dec_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    ctrl_wr && w_test && w_ts == 2'h1 |=> ##1 pump_source && !pump_sink)
    else $error("source test not decoded");
  var_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    ctrl_wr && w_test && wb[`SMSD_TSEL_HI_BIT] |=> ##1 varactor_off)
    else $error("varactor not disabled");
  port_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    ctrl_wr && w_test |=> port_reg[2:0] == $past(port_reg[2:0]))
    else $error("low ports overwritten");
  cur_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    ctrl_wr |=> ##1 pump_current == $past(wb[7:6], 2))
    else $error("pump current wrong");
  mode_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    !ctrl_wr |=> $stable(mode_reg) && $stable(out_reg))
    else $error("mode changed without write");
  adc_code_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    adc_sample >= `SMSD_ADC_T4 |-> adc_code == 3'h4)
    else $error("top adc range wrong");
  stat_fmt_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    status[5:3] == 3'h0 && status[2:0] == adc_code)
    else $error("status layout wrong");
  norm_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    mode_reg == SMSD_NORMAL |-> status[6] == lock_s)
    else $error("lock not passed in normal mode");
  ref_route_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    out_reg.shared_out_en && !out_reg.shared_sel_comp |=> shared_out == $past(ref_s))
    else $error("reference not routed");
  comp_route_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    out_reg.shared_out_en && out_reg.shared_sel_comp |=> shared_out == $past(comp_s))
    else $error("comparison not routed");
  sink_dec_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    ctrl_wr && w_test && w_ts == 2'h0 |=> ##1 pump_sink && !pump_source && !pump_off)
    else $error("sink test not decoded");
  off_dec_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    ctrl_wr && w_test && w_ts == 2'h2 |=> ##1 pump_off && !pump_sink && !pump_source)
    else $error("pump off test not decoded");
  norm_dec_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    ctrl_wr && !w_test |=> ##1 !pump_sink && !pump_source && !pump_off)
    else $error("test mode outside test");
  var_on_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    ctrl_wr && !(w_test && wb[`SMSD_TSEL_HI_BIT]) |=> ##1 !varactor_off)
    else $error("varactor disabled wrongly");
  port_half_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    mode_reg == SMSD_T_PORT |=> port_out[0] == $past(half_reg))
    else $error("port zero not half rate");
  port_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    ctrl_wr && !w_test |=> port_reg == $past(wb[3:0]))
    else $error("ports not loaded");
  adc_low_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    adc_sample < `SMSD_ADC_T1 |-> adc_code == 3'h0)
    else $error("low adc range wrong");
  adc_mid_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    adc_sample >= `SMSD_ADC_T2 && adc_sample < `SMSD_ADC_T3 |-> adc_code == 3'h2)
    else $error("mid adc range wrong");
  por_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    rd_en && hit_stat |=> !por_reg)
    else $error("power loss flag not cleared");
endmodule // smsd_top
`default_nettype wire

// [dv/smsd_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
module smsd_far_model (
  // Loop request
  input wire logic lock_req,
  // Analog side
  output logic ref_osc_in,
  output logic comp_freq_in,
  output logic phase_detector_freq,
  output logic loop_locked
);
  // Reference at 320 ns, detector at 640 ns, half its rate
  initial begin
    ref_osc_in = 1'b0;
    phase_detector_freq = 1'b0;
    forever begin
      #160 ref_osc_in = ~ref_osc_in;
      #160 ref_osc_in = ~ref_osc_in;
      phase_detector_freq = ~phase_detector_freq;
    end
  end
  // Slow comparison clock, static here
  assign comp_freq_in = 1'b0;
  assign loop_locked = lock_req;
endmodule // smsd_far_model
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, lock_req, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, ref_osc_in, comp_freq_in, phase_detector_freq, loop_locked;
  logic [9:0] adc_sample;
  logic shared_out, pump_sink, pump_source, pump_off, varactor_off, irq;
  logic [3:0] port_out, seen;
  logic [1:0] pump_current;
  int fail_count, samples_checked;
  smsd_top smsd_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ref_osc_in, .comp_freq_in, .phase_detector_freq,
    .loop_locked, .adc_sample, .shared_out, .port_out, .pump_current, .pump_sink,
    .pump_source, .pump_off, .varactor_off, .irq);
  smsd_far_model smsd_far_model_inst (.lock_req, .ref_osc_in, .comp_freq_in,
    .phase_detector_freq, .loop_locked);
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("wait", n, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] c);
    apb(1'b1, 12'h000, {24'h0, c});
    repeat (4) @(posedge pclk);
  endtask
  task look;
    seen = 4'h0;
    repeat (40) begin
      @(posedge pclk);
      seen |= {shared_out, ~shared_out, port_out[0], ~port_out[0]};
    end
  endtask
  task t_reset;
    apb(1'b0, 12'h000, 0);
    chk("ctrl", rd[7:0], 8'h30);
    look;
    chk("comp0", seen[3:2], 2'b01);
    apb(1'b0, 12'h004, 0);
    chk("por", rd[7:0], 8'hc0);
    apb(1'b0, 12'h010, 0);
    chk("unmap", {err, rd[30:0]}, 32'h80000000);
  endtask
  task t_share;
    wr(8'h20);
    look;
    chk("ref", seen[3:2], 2'b11);
    wr(8'h30);
    look;
    chk("comp", seen[3:2], 2'b01);
    wr(8'h00);
    look;
    chk("slave", {seen[3:2], pump_off, varactor_off}, 4'h8);
  endtask
  task t_cur;
    for (int c = 0; c < 4; c++) begin
      wr({c[1:0], 6'h30});
      chk("cur", pump_current, c[1:0]);
    end
  endtask
  task t_adc;
    logic [9:0] s [8] = '{10'h098, 10'h099, 10'h133, 10'h1cb, 10'h1cc, 10'h265,
      10'h266, 10'h3ff};
    logic [2:0] k [8] = '{0, 1, 2, 2, 3, 3, 4, 4};
    for (int j = 0; j < 8; j++) begin
      adc_sample <= s[j];
      repeat (3) @(posedge pclk);
      apb(1'b0, 12'h004, 0);
      chk("adc", rd[7:0], {5'h08, k[j]});
    end
    adc_sample <= 10'h000;
  endtask
  task t_modes;
    wr(8'h37);
    for (int i = 0; i < 8; i++) begin
      lock_req <= (i[1:0] != 2'b00);
      wr({5'h02, i[2:0]});
      look;
      chk("test", {pump_sink, pump_source, pump_off, varactor_off},
        {i[1:0] == 0, i[1:0] == 1, i[1:0] == 2, i[2]});
      chk("shared", seen[3:2], 2'b10);
      chk("port", {port_out[3:1], seen[1:0]}, {3'h3, 1'b1, i[1:0] == 3});
      apb(1'b0, 12'h004, 0);
      chk("lock", rd[7:0], {1'b0, i[1:0] == 0 || i[1:0] == 3, 6'h0});
    end
  endtask
  task t_irq;
    apb(1'b1, 12'h00c, 2);
    apb(1'b1, 12'h008, 3);
    repeat (2) @(posedge pclk);
    chk("irq0", irq, 0);
    adc_sample <= 10'h200;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h008, 0);
    chk("irq1", {irq, rd[1]}, 2'b11);
    apb(1'b1, 12'h008, 2);
    apb(1'b1, 12'h00c, 0);
    adc_sample <= 10'h000;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h008, 0);
    chk("irqm", {irq, rd[1]}, 2'b01);
  endtask
  task give_verdict;
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #2000000;
    fail_count++;
    give_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    lock_req = 1'b1;
    adc_sample = 10'h000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_share;
    t_cur;
    t_adc;
    t_modes;
    t_irq;
    give_verdict;
  end
endmodule // tb
`default_nettype wire
